// ---- mid_core.sv ----
// Move instruction decoder and executor with accumulators, stack and data pointers.
// Assumes program memory answers pm_addr combinationally on pm_data, and external
// modules return the source register named by pm_data on ext_rdata in the same cycle.
`timescale 1ns/1ps

module mid_core
    import mid_pkg::*;
#(
    parameter logic [15:0] RESET_VEC = RESET_IP
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Program memory
    output logic [15:0]      pm_addr,
    input  wire logic [15:0] pm_data,
    // External register modules
    input  wire logic [15:0] ext_rdata,
    output mid_wr_s          ext_wr,
    // Interrupt request and acknowledge
    input  wire logic        irq_req,
    output logic             irq_ack
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0]         ip;
    logic [15:0]         acc [NUM_ACC];
    logic [3:0]          ap;
    logic                carry;
    logic                zero;
    logic [PREFIX_W-1:0] destination_prefix_reg;
    logic [3:0]          stack_pointer_reg;
    logic [15:0]         stk [STK_DEPTH];
    logic                ie;
    logic [15:0]         dp [NUM_DP];
    logic [5:0]          dpc;
    logic [15:0]         ram [RAM_WORDS];

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic        imm;
    logic [3:0]  s_mod;
    logic [4:0]  s_idx;
    logic [3:0]  d_mod;
    logic [4:0]  d_idx;
    logic        take_irq;
    logic        exec;

    // One word is the whole instruction; no second word is ever fetched
    assign imm      = pm_data[FMT_BIT];
    assign s_mod    = pm_data[SMOD_LSB +: 4];
    assign s_idx    = {1'b0, pm_data[SIDX_LSB +: 4]};
    assign d_mod    = pm_data[DMOD_LSB +: 4];
    assign d_idx    = {destination_prefix_reg, pm_data[DSUB_LSB +: 3]};
    assign take_irq = irq_req && ie && (destination_prefix_reg == '0);
    assign exec     = !take_irq;

    // Destination strobes, one per internal module and one shared by all external modules
    logic w_alu, w_acc, w_sys, w_br, w_stk, w_dp, w_ext;
    assign w_alu = exec && d_mod == MOD_ALU;
    assign w_acc = exec && d_mod == MOD_ACC;
    assign w_sys = exec && d_mod == MOD_SYS;
    assign w_br  = exec && d_mod == MOD_BR;
    assign w_stk = exec && d_mod == MOD_STK;
    assign w_dp  = exec && d_mod == MOD_DP;
    assign w_ext = exec && d_mod < MOD_INT_BASE;

    // ------------------------------------------------------------
    // Source read, with read side effects flagged
    // ------------------------------------------------------------
    logic [15:0] src_val;
    logic        r_pop;
    logic [2:0]  r_dp;

    // Immediate byte or register value
    always_comb begin
        src_val = 16'h0000;
        r_pop   = 1'b0;
        r_dp    = 3'b000;
        if (imm) begin
            src_val = {8'h00, pm_data[7:0]};
        end else begin
            unique case (s_mod)
                MOD_ALU: src_val = acc[ap];
                MOD_ACC: src_val = acc[s_idx[3:0]];
                MOD_SYS: begin
                    case (s_idx)
                        SYS_AP:  src_val = {12'h000, ap};
                        SYS_PREFIX: src_val = {14'h0000, destination_prefix_reg};
                        SYS_STKPTR: src_val = {12'h000, stack_pointer_reg};
                        SYS_FLG: src_val = {14'h0000, carry, zero};
                        default: src_val = 16'h0000;
                    endcase
                end
                MOD_BR:  src_val = ip;
                MOD_STK: begin
                    src_val = stk[stack_pointer_reg];
                    r_pop   = exec;
                end
                MOD_DP: begin
                    if (s_idx < DP_MEM0) begin
                        src_val = dp[s_idx[1:0]];
                    end else if (s_idx < DP_CTL) begin
                        src_val = ram[dp[s_idx[1:0] - 2'd3][7:0]];
                        r_dp[s_idx[1:0] - 2'd3] = exec;
                    end else if (s_idx == DP_CTL) begin
                        src_val = {10'h000, dpc};
                    end
                end
                default: src_val = (s_mod < MOD_INT_BASE) ? ext_rdata : 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Arithmetic against the active accumulator
    // ------------------------------------------------------------
    logic [16:0] alu_res;

    // Any source combines with A[ap]
    always_comb begin
        alu_res = {carry, acc[ap]};
        unique case (d_idx)
            ALU_ADD:  alu_res = {1'b0, acc[ap]} + {1'b0, src_val};
            ALU_ADDC: alu_res = {1'b0, acc[ap]} + {1'b0, src_val} + {16'h0000, carry};
            ALU_SUB:  alu_res = {1'b0, acc[ap]} - {1'b0, src_val};
            ALU_SUBB: alu_res = {1'b0, acc[ap]} - {1'b0, src_val} - {16'h0000, carry};
            ALU_AND:  alu_res = {carry, acc[ap] & src_val};
            ALU_OR:   alu_res = {carry, acc[ap] | src_val};
            ALU_XOR:  alu_res = {carry, acc[ap] ^ src_val};
            ALU_MOV:  alu_res = {carry, src_val};
            default:  alu_res = {carry, acc[ap]};
        endcase
    end

    // ------------------------------------------------------------
    // Stack control
    // ------------------------------------------------------------
    logic push;
    logic pop;
    logic [15:0] push_val;

    assign push = take_irq || (w_br && d_idx == BR_CALL) || (w_stk && d_idx == STK_PUSH);
    assign pop  = r_pop || (w_stk && (d_idx == STK_RET || d_idx == STK_RETI));
    assign push_val = take_irq ? ip : (w_br ? ip + 16'h0001 : src_val);

    // Pre-increment on push, read-then-decrement on pop
    always_ff @(posedge mclk) begin
        if (rst) begin
            stack_pointer_reg <= STKPTR_RST;
        end else if (push && !pop) begin
            stack_pointer_reg <= stack_pointer_reg + 4'h1;
            stk[stack_pointer_reg + 4'h1] <= push_val;
        end else if (push && pop) begin
            stk[stack_pointer_reg] <= push_val;
        end else if (pop) begin
            stack_pointer_reg <= stack_pointer_reg - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Instruction pointer and interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            ip <= RESET_VEC;
        end else if (take_irq) begin
            ip <= IRQ_VEC;
        end else if (w_stk && (d_idx == STK_RET || d_idx == STK_RETI)) begin
            ip <= stk[stack_pointer_reg];
        end else if (w_br && (d_idx == BR_JUMP || d_idx == BR_CALL ||
                 (d_idx == BR_JC && carry) || (d_idx == BR_JZ && zero))) begin
            ip <= src_val;
        end else begin
            ip <= ip + 16'h0001;
        end
    end

    // Interrupts masked while one is serviced
    always_ff @(posedge mclk) begin
        if (rst) begin
            ie <= 1'b1;
        end else if (take_irq) begin
            ie <= 1'b0;
        end else if (w_stk && d_idx == STK_RETI) begin
            ie <= 1'b1;
        end
    end

    // Acknowledge pulse in the cycle after vectoring
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= take_irq;
        end
    end

    assign pm_addr = ip;

    // ------------------------------------------------------------
    // Accumulators, flags and accumulator pointer
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_ACC; i++) begin
                acc[i] <= 16'h0000;
            end
        end else if (w_alu) begin
            acc[ap] <= alu_res[15:0];
        end else if (w_acc && d_idx < 5'(NUM_ACC)) begin
            acc[d_idx[3:0]] <= src_val;
        end
    end

    // Flags follow arithmetic results
    always_ff @(posedge mclk) begin
        if (rst) begin
            carry <= 1'b0;
            zero  <= 1'b0;
        end else if (w_alu) begin
            carry <= alu_res[16];
            zero  <= (alu_res[15:0] == 16'h0000);
        end else if (w_sys && d_idx == SYS_FLG) begin
            carry <= src_val[1];
            zero  <= src_val[0];
        end
    end

    // Active accumulator select
    always_ff @(posedge mclk) begin
        if (rst) begin
            ap <= 4'h0;
        end else if (w_sys && d_idx == SYS_AP) begin
            ap <= src_val[3:0];
        end
    end

    // ------------------------------------------------------------
    // Destination prefix: holds for exactly one following word
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            destination_prefix_reg <= '0;
        end else if (w_sys && d_idx == SYS_PREFIX) begin
            destination_prefix_reg <= src_val[PREFIX_W-1:0];
        end else if (exec) begin
            destination_prefix_reg <= '0;
        end
    end

    // ------------------------------------------------------------
    // Data pointers with post-adjust, and data memory
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            dpc <= 6'h00;
        end else if (w_dp && d_idx == DP_CTL) begin
            dpc <= src_val[5:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_DP; g++) begin : g_dp
            logic wr_ptr;
            logic acc_mem;
            assign wr_ptr  = w_dp && d_idx == 5'(g);
            assign acc_mem = r_dp[g] || (w_dp && d_idx == 5'(g) + DP_MEM0);

            // Pointer load or automatic step after a memory access
            always_ff @(posedge mclk) begin
                if (rst) begin
                    dp[g] <= 16'h0000;
                end else if (wr_ptr) begin
                    dp[g] <= src_val;
                end else if (acc_mem && dpc[2*g +: 2] == DPM_INC) begin
                    dp[g] <= dp[g] + 16'h0001;
                end else if (acc_mem && dpc[2*g +: 2] == DPM_DEC) begin
                    dp[g] <= dp[g] - 16'h0001;
                end
            end
        end
    endgenerate

    // Memory write through a pointer
    always_ff @(posedge mclk) begin
        if (w_dp && d_idx >= DP_MEM0 && d_idx < DP_CTL) begin
            ram[dp[d_idx[1:0] - 2'd3][7:0]] <= src_val;
        end
    end

    // ------------------------------------------------------------
    // External module writes
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            ext_wr <= '0;
        end else begin
            ext_wr.valid <= w_ext;
            ext_wr.mod   <= d_mod;
            ext_wr.idx   <= d_idx;
            ext_wr.data  <= src_val;
        end
    end

endmodule

// ---- mid_pkg.sv ----
// Constants, field layouts and carrier types for the move instruction decoder.
// Assumes a single core clock and a synchronous active-high core reset.
package mid_pkg;

    // ------------------------------------------------------------
    // Instruction word fields
    // ------------------------------------------------------------
    localparam int FMT_BIT  = 15;
    localparam int SMOD_LSB = 0;
    localparam int SIDX_LSB = 4;
    localparam int DMOD_LSB = 8;
    localparam int DSUB_LSB = 12;

    // ------------------------------------------------------------
    // Module specifiers; below MOD_INT_BASE the modules are external
    // ------------------------------------------------------------
    localparam logic [3:0] MOD_INT_BASE = 4'h8;
    localparam logic [3:0] MOD_ALU      = 4'h8;
    localparam logic [3:0] MOD_ACC      = 4'h9;
    localparam logic [3:0] MOD_SYS      = 4'hA;
    localparam logic [3:0] MOD_BR       = 4'hB;
    localparam logic [3:0] MOD_STK      = 4'hC;
    localparam logic [3:0] MOD_DP       = 4'hD;

    // ------------------------------------------------------------
    // Register indexes inside the internal modules
    // ------------------------------------------------------------
    localparam logic [4:0] ALU_ADD  = 5'h00;
    localparam logic [4:0] ALU_ADDC = 5'h01;
    localparam logic [4:0] ALU_SUB  = 5'h02;
    localparam logic [4:0] ALU_SUBB = 5'h03;
    localparam logic [4:0] ALU_AND  = 5'h04;
    localparam logic [4:0] ALU_OR   = 5'h05;
    localparam logic [4:0] ALU_XOR  = 5'h06;
    localparam logic [4:0] ALU_MOV  = 5'h07;
    localparam logic [4:0] SYS_AP   = 5'h00;
    localparam logic [4:0] SYS_PREFIX = 5'h01;
    localparam logic [4:0] SYS_STKPTR = 5'h02;
    localparam logic [4:0] SYS_FLG  = 5'h03;
    localparam logic [4:0] BR_JUMP  = 5'h00;
    localparam logic [4:0] BR_JC    = 5'h01;
    localparam logic [4:0] BR_JZ    = 5'h02;
    localparam logic [4:0] BR_CALL  = 5'h03;
    localparam logic [4:0] STK_PUSH = 5'h00;
    localparam logic [4:0] STK_RET  = 5'h01;
    localparam logic [4:0] STK_RETI = 5'h02;
    localparam logic [4:0] DP_MEM0  = 5'h03;
    localparam logic [4:0] DP_CTL   = 5'h06;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int         NUM_ACC    = 16;
    localparam int         STK_DEPTH  = 16;
    localparam int         NUM_DP     = 3;
    localparam int         RAM_WORDS  = 256;
    localparam int         PREFIX_W   = 2;
    localparam logic [3:0] STKPTR_RST = 4'hF;
    localparam logic [15:0] RESET_IP  = 16'h0000;
    localparam logic [15:0] IRQ_VEC   = 16'h0020;
    localparam logic [1:0] DPM_NONE   = 2'h0;
    localparam logic [1:0] DPM_INC    = 2'h1;
    localparam logic [1:0] DPM_DEC    = 2'h2;

    // External register write carrier
    typedef struct packed {
        logic        valid;
        logic [3:0]  mod;
        logic [4:0]  idx;
        logic [15:0] data;
    } mid_wr_s;

endpackage

// ---- mid_core_properties.sv ----
// Port-level checks of the move decoder.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps

module mid_core_properties
    import mid_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // Program memory
    input wire logic [15:0] pm_addr,
    input wire logic [15:0] pm_data,
    // External registers
    input wire logic [15:0] ext_rdata,
    input wire mid_wr_s     ext_wr,
    // Interrupt
    input wire logic        irq_req,
    input wire logic        irq_ack
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Word moving to an external module, not displaced by an interrupt
    sequence s_ext_word;
        !irq_req && pm_data[11:8] < MOD_INT_BASE;
    endsequence
    // Immediate write of the destination prefix
    sequence s_prefix_word;
        !irq_req && pm_data[FMT_BIT] && pm_data[14:8] == {3'h1, MOD_SYS};
    endsequence

    ext_write_out_a: assert property (s_ext_word |=> ext_wr.valid &&
        ext_wr.mod == $past(pm_data[11:8]) && ext_wr.idx[2:0] == $past(pm_data[14:12]))
        else $error("external write missing or misaddressed");
    imm_source_data_a: assert property (s_ext_word ##0 pm_data[FMT_BIT] |=>
        ext_wr.data == {8'h00, $past(pm_data[7:0])})
        else $error("immediate source data wrong");
    reg_source_data_a: assert property (s_ext_word ##0 !pm_data[FMT_BIT] &&
        pm_data[3:0] < MOD_INT_BASE |=> ext_wr.data == $past(ext_rdata))
        else $error("register source data wrong");
    internal_no_write_a: assert property (pm_data[11:8] >= MOD_INT_BASE |=>
        !ext_wr.valid) else $error("write pulse for internal destination");
    prefix_extends_idx_a: assert property (s_prefix_word ##1
        pm_data[11:8] < MOD_INT_BASE |=> ext_wr.valid &&
        ext_wr.idx == {$past(pm_data[1:0], 2), $past(pm_data[14:12])})
        else $error("prefix bits not applied");
    prefix_clears_a: assert property (s_prefix_word ##1
        pm_data[14:8] != {3'h1, MOD_SYS} ##1 s_ext_word |=> ext_wr.idx[4:3] == 2'h0)
        else $error("prefix outlived one word");
    ip_sequential_a: assert property (s_ext_word |=>
        pm_addr == $past(pm_addr) + 16'h0001) else $error("fetch not one per cycle");
    jump_target_a: assert property (!irq_req && pm_data[FMT_BIT] &&
        $past(pm_data[14:8]) != {3'h1, MOD_SYS} &&
        pm_data[14:8] == {3'h0, MOD_BR} |=> pm_addr == {8'h00, $past(pm_data[7:0])})
        else $error("jump target wrong");
    ack_one_cycle_a: assert property (irq_ack |=> !irq_ack)
        else $error("acknowledge longer than one cycle");
    ack_at_vector_a: assert property (irq_ack |->
        pm_addr == IRQ_VEC || $past(pm_addr) == IRQ_VEC)
        else $error("acknowledge without vectoring");
endmodule

// ---- mid_pm_model.sv ----
// Program memory and external register modules facing the decoder.
// Assumes the testbench loads rom hierarchically while the core is in reset.
`timescale 1ns/1ps

module mid_pm_model
    import mid_pkg::*;
(
    // Clock
    input  wire logic        mclk,
    // Program memory
    input  wire logic [15:0] pm_addr,
    output logic [15:0]      pm_data,
    // External registers
    input  wire mid_wr_s     ext_wr,
    output logic [15:0]      ext_rdata
);
    logic [15:0] rom   [0:255];
    logic [15:0] regs  [0:255];
    logic [15:0] noise;

    // Registers start cleared, the pattern at zero
    initial begin
        noise = 16'h0000;
        for (int i = 0; i < 256; i++)
            regs[i] = 16'h0000;
    end

    // Fetch answers in the same cycle
    assign pm_data = rom[pm_addr[7:0]];

    // Unselected read data keeps changing so stale values never match
    always_comb begin
        if (!pm_data[FMT_BIT] && !pm_data[3])
            ext_rdata = regs[{pm_data[2:0], 1'b0, pm_data[7:4]}];
        else
            ext_rdata = noise;
    end

    // Store writes, advance the pattern
    always @(posedge mclk) begin
        noise <= noise + 16'h3C5B;
        if (ext_wr.valid === 1'b1)
            regs[{ext_wr.mod[2:0], ext_wr.idx}] <= ext_wr.data;
    end
endmodule

// ---- tb_move_instruction_decoder.sv ----
// Self-checking bench for the move decoder: one task per scenario.
// Assumes mid_core, mid_pm_model and mid_core_properties are compiled first.
`timescale 1ns/1ps

module tb_move_instruction_decoder;
    import mid_pkg::*;

    logic        mclk;
    logic        rst;
    logic        irq_req;
    logic        irq_ack;
    logic [15:0] pm_addr;
    logic [15:0] pm_data;
    logic [15:0] ext_rdata;
    mid_wr_s     ext_wr;
    int          n_mismatch;
    int          checked;
    int          waited;
    int          n_ack;

    mid_core u_mid_core (.mclk(mclk), .rst(rst), .pm_addr(pm_addr), .pm_data(pm_data),
        .ext_rdata(ext_rdata), .ext_wr(ext_wr), .irq_req(irq_req), .irq_ack(irq_ack));
    mid_pm_model u_mid_pm_model (.mclk(mclk), .pm_addr(pm_addr), .pm_data(pm_data),
        .ext_wr(ext_wr), .ext_rdata(ext_rdata));

    // ----------------------------------------
    // Clock, watchdog, acknowledge count
    // ----------------------------------------
    always #20 mclk = ~mclk;
    initial begin
        #800000;
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
    always @(posedge mclk) begin
        if (irq_ack === 1'b1)
            n_ack <= n_ack + 1;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] imm(input logic [3:0] dm, input logic [2:0] ds,
        input logic [7:0] v);
        return {1'b1, ds, dm, v};
    endfunction
    function automatic logic [15:0] mvr(input logic [3:0] dm, input logic [2:0] ds,
        input logic [3:0] sm, input logic [3:0] si);
        return {1'b0, ds, dm, si, sm};
    endfunction
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    // Next write pulse must carry exactly this module, index and data
    task automatic expect_wr(input logic [3:0] m, input logic [4:0] i,
        input logic [15:0] d);
        mid_wr_s exp;
        exp = {1'b1, m, i, d};
        waited = 0;
        while (waited < 20) begin
            @(posedge mclk);
            waited++;
            if (ext_wr.valid === 1'b1)
                break;
        end
        checked++;
        if (ext_wr !== exp) begin
            n_mismatch++;
            $display("Error at %0t: write %h expected %h", $time, ext_wr, exp);
        end
    endtask
    // Hold reset and fill memory with a marker write to module 7
    task automatic load();
        rst <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 256; i++)
            u_mid_pm_model.rom[i] = 16'hF7FF;
    endtask
    task automatic go();
        @(posedge mclk);
        rst <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_moves();
        load();
        u_mid_pm_model.rom[0] = 16'h8342;
        u_mid_pm_model.rom[1] = imm(4'h5, 3'h7, 8'hFF);
        u_mid_pm_model.rom[2] = imm(4'h2, 3'h3, 8'h5A);
        u_mid_pm_model.rom[3] = imm(MOD_SYS, 3'h0, 8'h00);
        u_mid_pm_model.rom[4] = mvr(4'h4, 3'h1, 4'h2, 4'h3);
        u_mid_pm_model.rom[5] = imm(4'h4, 3'h1, 8'h32);
        go();
        expect_wr(4'h3, 5'h00, 16'h0042);
        chk16(16'(waited), 16'h0002);
        expect_wr(4'h5, 5'h07, 16'h00FF);
        expect_wr(4'h2, 5'h03, 16'h005A);
        expect_wr(4'h4, 5'h01, 16'h005A);
        expect_wr(4'h4, 5'h01, 16'h0032);
    endtask

    task automatic s_prefix();
        load();
        u_mid_pm_model.rom[0] = imm(MOD_SYS, 3'h1, 8'h01);
        u_mid_pm_model.rom[1] = imm(4'h6, 3'h2, 8'h11);
        u_mid_pm_model.rom[2] = imm(4'h6, 3'h2, 8'h22);
        u_mid_pm_model.rom[3] = imm(MOD_SYS, 3'h1, 8'h03);
        u_mid_pm_model.rom[4] = imm(4'h6, 3'h7, 8'h33);
        go();
        expect_wr(4'h6, 5'h0A, 16'h0011);
        chk16(16'(waited), 16'h0003);
        expect_wr(4'h6, 5'h02, 16'h0022);
        expect_wr(4'h6, 5'h1F, 16'h0033);
    endtask

    task automatic s_alu();
        load();
        u_mid_pm_model.rom[0] = imm(MOD_ALU, 3'h7, 8'h10);
        u_mid_pm_model.rom[1] = imm(MOD_ALU, 3'h0, 8'h05);
        u_mid_pm_model.rom[2] = imm(4'h1, 3'h0, 8'h80);
        u_mid_pm_model.rom[3] = imm(MOD_SYS, 3'h0, 8'h00);
        u_mid_pm_model.rom[4] = mvr(MOD_ALU, 3'h5, 4'h1, 4'h0);
        u_mid_pm_model.rom[5] = mvr(4'h3, 3'h0, MOD_ALU, 4'h0);
        u_mid_pm_model.rom[6] = imm(MOD_SYS, 3'h0, 8'h03);
        u_mid_pm_model.rom[7] = imm(MOD_ALU, 3'h7, 8'h77);
        u_mid_pm_model.rom[8] = mvr(4'h3, 3'h1, MOD_ALU, 4'h0);
        u_mid_pm_model.rom[9] = imm(MOD_SYS, 3'h0, 8'h00);
        u_mid_pm_model.rom[10] = mvr(4'h3, 3'h2, MOD_ALU, 4'h0);
        go();
        expect_wr(4'h1, 5'h00, 16'h0080);
        expect_wr(4'h3, 5'h00, 16'h0095);
        expect_wr(4'h3, 5'h01, 16'h0077);
        expect_wr(4'h3, 5'h02, 16'h0095);
    endtask

    task automatic s_branch_stack();
        load();
        u_mid_pm_model.rom[0] = imm(MOD_BR, 3'h0, 8'h40);
        u_mid_pm_model.rom[64] = imm(MOD_STK, 3'h0, 8'h33);
        u_mid_pm_model.rom[65] = mvr(4'h3, 3'h0, MOD_SYS, 4'h2);
        u_mid_pm_model.rom[66] = mvr(4'h3, 3'h1, MOD_STK, 4'h0);
        u_mid_pm_model.rom[67] = mvr(4'h3, 3'h2, MOD_SYS, 4'h2);
        u_mid_pm_model.rom[68] = imm(MOD_BR, 3'h3, 8'h50);
        u_mid_pm_model.rom[80] = mvr(4'h3, 3'h3, MOD_SYS, 4'h2);
        u_mid_pm_model.rom[81] = imm(MOD_STK, 3'h1, 8'h00);
        u_mid_pm_model.rom[69] = imm(4'h3, 3'h4, 8'h45);
        go();
        expect_wr(4'h3, 5'h00, 16'h0000);
        expect_wr(4'h3, 5'h01, 16'h0033);
        expect_wr(4'h3, 5'h02, 16'h000F);
        expect_wr(4'h3, 5'h03, 16'h0000);
        expect_wr(4'h3, 5'h04, 16'h0045);
    endtask

    task automatic s_pointers();
        load();
        u_mid_pm_model.rom[0] = imm(MOD_DP, 3'h6, 8'h01);
        u_mid_pm_model.rom[1] = imm(MOD_DP, 3'h0, 8'h10);
        u_mid_pm_model.rom[2] = imm(MOD_DP, 3'h3, 8'hAA);
        u_mid_pm_model.rom[3] = imm(MOD_DP, 3'h3, 8'hBB);
        u_mid_pm_model.rom[4] = mvr(4'h3, 3'h0, MOD_DP, 4'h0);
        u_mid_pm_model.rom[5] = imm(MOD_DP, 3'h0, 8'h10);
        u_mid_pm_model.rom[6] = mvr(4'h3, 3'h1, MOD_DP, 4'h3);
        u_mid_pm_model.rom[7] = imm(MOD_DP, 3'h6, 8'h02);
        u_mid_pm_model.rom[8] = mvr(4'h3, 3'h2, MOD_DP, 4'h3);
        u_mid_pm_model.rom[9] = imm(MOD_DP, 3'h6, 8'h00);
        u_mid_pm_model.rom[10] = mvr(4'h3, 3'h3, MOD_DP, 4'h3);
        u_mid_pm_model.rom[11] = mvr(4'h3, 3'h4, MOD_DP, 4'h0);
        go();
        expect_wr(4'h3, 5'h00, 16'h0012);
        expect_wr(4'h3, 5'h01, 16'h00AA);
        expect_wr(4'h3, 5'h02, 16'h00BB);
        expect_wr(4'h3, 5'h03, 16'h00AA);
        expect_wr(4'h3, 5'h04, 16'h0010);
    endtask

    task automatic s_interrupt();
        load();
        u_mid_pm_model.rom[0] = imm(4'h5, 3'h1, 8'h01);
        u_mid_pm_model.rom[32] = imm(4'h5, 3'h0, 8'h20);
        u_mid_pm_model.rom[33] = imm(MOD_STK, 3'h2, 8'h00);
        n_ack = 0;
        irq_req <= 1'b1;
        go();
        expect_wr(4'h5, 5'h00, 16'h0020);
        irq_req <= 1'b0;
        expect_wr(4'h5, 5'h01, 16'h0001);
        repeat (2) @(posedge mclk);
        chk16(16'(n_ack), 16'h0001);
    endtask

    // Borrow, carry-in, conditional jumps, flag reads and accumulator moves
    task automatic s_flags();
        load();
        u_mid_pm_model.rom[0] = imm(MOD_ALU, 3'h7, 8'h05);
        u_mid_pm_model.rom[1] = imm(MOD_ALU, 3'h2, 8'h06);
        u_mid_pm_model.rom[2] = imm(MOD_BR, 3'h1, 8'h10);
        u_mid_pm_model.rom[3] = imm(4'h3, 3'h0, 8'hEE);
        u_mid_pm_model.rom[16] = mvr(4'h3, 3'h0, MOD_SYS, 4'h3);
        u_mid_pm_model.rom[17] = imm(MOD_ALU, 3'h1, 8'h00);
        u_mid_pm_model.rom[18] = imm(MOD_BR, 3'h2, 8'h20);
        u_mid_pm_model.rom[19] = imm(4'h3, 3'h1, 8'hEE);
        u_mid_pm_model.rom[32] = imm(MOD_ACC, 3'h2, 8'h3C);
        u_mid_pm_model.rom[33] = mvr(4'h3, 3'h1, MOD_ACC, 4'h2);
        u_mid_pm_model.rom[34] = mvr(4'h3, 3'h2, MOD_SYS, 4'h3);
        u_mid_pm_model.rom[35] = imm(MOD_ALU, 3'h6, 8'hFF);
        u_mid_pm_model.rom[36] = mvr(4'h3, 3'h3, MOD_ALU, 4'h0);
        go();
        expect_wr(4'h3, 5'h00, 16'h0002);
        expect_wr(4'h3, 5'h01, 16'h003C);
        expect_wr(4'h3, 5'h02, 16'h0003);
        expect_wr(4'h3, 5'h03, 16'h00FF);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        irq_req = 1'b0;
        n_mismatch = 0;
        checked = 0;
        n_ack = 0;
        repeat (20) @(posedge mclk);
        s_moves();
        s_prefix();
        s_alu();
        s_branch_stack();
        s_pointers();
        s_flags();
        s_interrupt();
        conclude();
    end
endmodule

bind mid_core mid_core_properties u_mid_core_properties (.mclk(mclk), .rst(rst),
    .pm_addr(pm_addr), .pm_data(pm_data), .ext_rdata(ext_rdata), .ext_wr(ext_wr),
    .irq_req(irq_req), .irq_ack(irq_ack));
